// >>> hdl/tpl_loader.sv
// tone table loader: programming port, tone tables, programmed tone checks
// assumes bus strobes, mode levels and filter outputs on sys_clk_in
`timescale 1ns/1ps

// Notes on behaviour
// - sixteen-bit write-only programming port into RAM
// - powersave clears the tone tables, reset loads the defaults
// - write clears ready; set again when processed
// - four transmit pairs, two tones, frequency and level
// - transmit header 8000, data up to 3FFF
// - sixteen transmit words, pairs a-d in order
// - zero frequency and level means silent tone
// - after reset only pair d sounds
// - receive header 8001, data up to 7FFF
// - twenty-six receive words, two channel layouts
// - coefficients fifteen-bit signed, top bit zero
// - detector counts ticks over programmed cycle count
// - pass only between minimum and maximum time
// - level detector turns on at or above on level, off below off level
// - new receive values apply at next mode entry
// - after reset default two-tone detector is active
// - status b7 second tone, b6 first tone
module tpl_loader #(
    parameter int PROC_CYCLES = tpl_pkg::PROC_CYCLES_DEF,
    parameter int TICK_DIV    = tpl_pkg::TICK_DIV_DEF
) (
    // clock and reset
    input  wire logic                   sys_clk_in,
    input  wire logic                   reset_n_in,
    // control bus write port
    input  wire logic                   wr_en_in,
    input  wire logic [7:0]             addr_in,
    input  wire logic [15:0]            wdata_in,
    output logic                        prog_ready_out,
    // device state
    input  wire logic                   gen_reset_in,
    input  wire logic                   powersave_in,
    input  wire logic                   ptd_mode_in,
    // transmit table to tone generator
    input  wire logic [1:0]             tx_pair_sel_in,
    output tpl_pkg::tpl_tone_t          tx_tone1_out,
    output tpl_pkg::tpl_tone_t          tx_tone2_out,
    output logic                        tx_tone1_on_out,
    output logic                        tx_tone2_on_out,
    // receive coefficients to filters
    input  wire logic [4:0]             coef_sel_in,
    output logic [15:0]                 coef_out,
    // filter outputs per channel
    input  wire logic [1:0]             cycle_in,
    input  wire logic [1:0][15:0]       level_in,
    // detect status
    output logic                        tone1_det_out,
    output logic                        tone2_det_out,
    output logic                        pair_det_out
);
    import tpl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // write decode

    tpl_sel_t          sel;
    logic [4:0]        word_idx;
    logic [15:0]       busy_cnt;
    logic [15:0][15:0] tx_ram;
    logic [25:0][15:0] rx_ram;
    logic [25:0][15:0] rx_act;
    logic              ptd_q;
    logic [14:0]       tick_cnt;
    logic              tick;
    logic [1:0]        det;

    wire clr_tables = powersave_in;
    wire hard_reset = !reset_n_in || gen_reset_in;
    wire port_wr    = wr_en_in && (addr_in == PROG_PORT_ADDR);
    wire is_hdr_tx  = port_wr && (wdata_in == HDR_TX);
    wire is_hdr_rx  = port_wr && (wdata_in == HDR_RX);
    wire is_data    = port_wr && !is_hdr_tx && !is_hdr_rx;
    wire tx_wr      = is_data && (sel == TPL_SEL_TX) && (word_idx < TX_WORDS)
                      && (wdata_in <= TX_DATA_MAX);
    wire rx_wr      = is_data && (sel == TPL_SEL_RX) && (word_idx < RX_WORDS)
                      && (wdata_in <= RX_DATA_MAX);
    wire activate   = ptd_mode_in && !ptd_q;
    wire [15:0] proc_load = 16'(PROC_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // header selection and word index

    always_ff @(posedge sys_clk_in) begin
        if (hard_reset || clr_tables) begin
            sel      <= TPL_SEL_NONE;
            word_idx <= 5'h00;
        end else if (is_hdr_tx) begin
            sel      <= TPL_SEL_TX;
            word_idx <= 5'h00;
        end else if (is_hdr_rx) begin
            sel      <= TPL_SEL_RX;
            word_idx <= 5'h00;
        end else if (tx_wr || rx_wr) begin
            word_idx <= word_idx + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ready flag handshake

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            prog_ready_out <= 1'b1;
            busy_cnt       <= 16'h0000;
        end else if (port_wr) begin
            prog_ready_out <= 1'b0;
            busy_cnt       <= proc_load;
        end else if (busy_cnt != 16'h0000) begin
            busy_cnt <= busy_cnt - 16'h0001;
            if (busy_cnt == 16'h0001) begin
                prog_ready_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tone table RAM

    always_ff @(posedge sys_clk_in) begin
        if (hard_reset) begin
            tx_ram <= TX_DEF;
        end else if (clr_tables) begin
            tx_ram <= '0;
        end else if (tx_wr) begin
            tx_ram[word_idx[3:0]] <= wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (hard_reset) begin
            rx_ram <= RX_DEF;
        end else if (clr_tables) begin
            rx_ram <= '0;
        end else if (rx_wr) begin
            rx_ram[word_idx] <= wdata_in;
        end
    end

    // active copy, refreshed only on entry into programmed tone mode
    always_ff @(posedge sys_clk_in) begin
        if (hard_reset) begin
            rx_act <= RX_DEF;
            ptd_q  <= 1'b0;
        end else begin
            ptd_q <= ptd_mode_in;
            if (activate) begin
                rx_act <= rx_ram;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit and coefficient read-out

    wire [3:0] pair_base = {tx_pair_sel_in, 2'b00};
    wire [15:0] f1 = tx_ram[pair_base];
    wire [15:0] l1 = tx_ram[pair_base + 4'h1];
    wire [15:0] f2 = tx_ram[pair_base + 4'h2];
    wire [15:0] l2 = tx_ram[pair_base + 4'h3];
    wire [15:0] coef_sel = (coef_sel_in < RX_WORDS) ? rx_act[coef_sel_in] : 16'h0000;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            tx_tone1_out    <= '0;
            tx_tone2_out    <= '0;
            tx_tone1_on_out <= 1'b0;
            tx_tone2_on_out <= 1'b0;
            coef_out        <= 16'h0000;
        end else begin
            tx_tone1_out    <= '{freq: f1, level: l1};
            tx_tone2_out    <= '{freq: f2, level: l2};
            tx_tone1_on_out <= (f1 != 16'h0000) || (l1 != 16'h0000);
            tx_tone2_on_out <= (f2 != 16'h0000) || (l2 != 16'h0000);
            coef_out        <= coef_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 9.6 kHz timer tick

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || tick) begin
            tick_cnt <= 15'h0000;
        end else begin
            tick_cnt <= tick_cnt + 15'h0001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 15'(TICK_DIV - 2));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per channel frequency and level detection

    for (genvar g = 0; g < 2; g++) begin : g_chan
        tpl_fchk_t   fc;
        logic [15:0] cyc;
        logic [15:0] tim;
        logic        fok;
        logic        lvl_on;

        assign fc = '{ncycles: rx_act[g * RX_CH_WORDS + RX_NCYC_OFS],
                      mintime: rx_act[g * RX_CH_WORDS + RX_MIN_OFS],
                      maxtime: rx_act[g * RX_CH_WORDS + RX_MAX_OFS]};
        wire tim_in_win = (tim >= fc.mintime) && (tim <= fc.maxtime);

        always_ff @(posedge sys_clk_in) begin
            if (!reset_n_in || !ptd_mode_in) begin
                cyc <= 16'h0000;
                tim <= 16'h0000;
                fok <= 1'b0;
            end else begin
                if (tick && tim != 16'hFFFF) begin
                    tim <= tim + 16'h0001;
                end
                if (tim > fc.maxtime) begin
                    fok <= 1'b0;
                end
                if (cycle_in[g]) begin
                    if (cyc == 16'h0000) begin
                        cyc <= 16'h0001;
                        tim <= 16'h0000;
                    end else if (cyc >= fc.ncycles) begin
                        fok <= tim_in_win;
                        cyc <= 16'h0001;
                        tim <= 16'h0000;
                    end else begin
                        cyc <= cyc + 16'h0001;
                    end
                end
            end
        end

        always_ff @(posedge sys_clk_in) begin
            if (!reset_n_in) begin
                lvl_on <= 1'b0;
            end else if (level_in[g] >= LVL_ON_THR) begin
                lvl_on <= 1'b1;
            end else if (level_in[g] < LVL_OFF_THR) begin
                lvl_on <= 1'b0;
            end
        end

        assign det[g] = lvl_on && fok && ptd_mode_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            tone1_det_out <= 1'b0;
            tone2_det_out <= 1'b0;
            pair_det_out  <= 1'b0;
        end else begin
            tone1_det_out <= det[0];
            tone2_det_out <= det[1];
            pair_det_out  <= det[0] && det[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    write_clears_ready_a: assert property (port_wr |=> !prog_ready_out)
        else $error("ready flag not cleared by port write");

    ready_returns_a: assert property (busy_cnt == 16'h0001 && !port_wr
        |=> prog_ready_out && busy_cnt == 16'h0000)
        else $error("ready flag did not return after processing");

    ready_stays_low_a: assert property (port_wr ##1 (busy_cnt > 16'h0001)
        |-> !prog_ready_out)
        else $error("ready flag rose while still busy");

    header_resets_idx_a: assert property ((is_hdr_tx || is_hdr_rx) && !clr_tables
        && !gen_reset_in |=> word_idx == 5'h00)
        else $error("header did not reset word index");

    tx_range_drop_a: assert property (is_data && sel == TPL_SEL_TX
        && wdata_in > TX_DATA_MAX && !clr_tables && !gen_reset_in
        |=> $stable(word_idx) && $stable(tx_ram))
        else $error("out of range transmit word was stored");

    rx_store_a: assert property (rx_wr && !clr_tables && !gen_reset_in
        |=> rx_ram[$past(word_idx)] == $past(wdata_in)
            && word_idx == $past(word_idx) + 5'h01)
        else $error("receive word not stored at index");

    powersave_clear_a: assert property (clr_tables && !gen_reset_in
        |=> tx_ram == '0 && rx_ram == '0)
        else $error("tables not cleared by powersave");

    reset_pair_d_a: assert property (gen_reset_in
        |=> tx_ram == TX_DEF && rx_act == RX_DEF)
        else $error("reset defaults not loaded");

    active_holds_a: assert property (ptd_q && ptd_mode_in && !gen_reset_in
        |=> $stable(rx_act))
        else $error("active coefficients changed during detect mode");

    tone_silent_a: assert property (f1 == 16'h0000 && l1 == 16'h0000
        |=> !tx_tone1_on_out)
        else $error("zero tone reported as sounding");

    level_hyst_a: assert property (level_in[0] < LVL_OFF_THR
        |=> !g_chan[0].lvl_on ##1 !tone1_det_out)
        else $error("level detector stayed on below off level");

    other_addr_a: assert property (wr_en_in && addr_in != PROG_PORT_ADDR
        && busy_cnt == 16'h0000 |=> prog_ready_out)
        else $error("write to another address cleared ready flag");

    tx_store_a: assert property (tx_wr && !clr_tables && !gen_reset_in
        |=> tx_ram[$past(word_idx[3:0])] == $past(wdata_in))
        else $error("transmit word not stored at index");

    rx_range_drop_a: assert property (is_data && sel == TPL_SEL_RX
        && wdata_in > RX_DATA_MAX && !clr_tables && !gen_reset_in
        |=> $stable(word_idx) && $stable(rx_ram))
        else $error("out of range receive word was stored");

    pass_in_window_a: assert property ($rose(g_chan[0].fok)
        |-> $past(g_chan[0].tim) >= $past(g_chan[0].fc.mintime)
            && $past(g_chan[0].tim) <= $past(g_chan[0].fc.maxtime))
        else $error("frequency check passed outside its window");

    late_drops_pass_a: assert property (g_chan[1].fok
        && g_chan[1].tim > g_chan[1].fc.maxtime |=> !g_chan[1].fok)
        else $error("frequency check held past maximum time");

    pair_needs_both_a: assert property (pair_det_out
        |-> tone1_det_out && tone2_det_out)
        else $error("pair detected without both tones");

endmodule

// >>> hdl/tpl_pkg.sv
// constants and carrier types for the tone pair program loader
// assumes a 250 MHz device clock and a byte address on the control bus
package tpl_pkg;

    // control bus address of the write-only programming port
    localparam logic [7:0]  PROG_PORT_ADDR = 8'hE8;

    // header words and data word limits
    localparam logic [15:0] HDR_TX         = 16'h8000;
    localparam logic [15:0] HDR_RX         = 16'h8001;
    localparam logic [15:0] TX_DATA_MAX    = 16'h3FFF;
    localparam logic [15:0] RX_DATA_MAX    = 16'h7FFF;

    // table sizes in words, header not counted
    localparam logic [4:0]  TX_WORDS       = 5'h10;
    localparam logic [4:0]  RX_WORDS       = 5'h1A;
    localparam int          RX_CH_WORDS    = 13;
    localparam int          RX_NCYC_OFS    = 10;
    localparam int          RX_MIN_OFS     = 11;
    localparam int          RX_MAX_OFS     = 12;

    // timing
    localparam int          CLK_HZ         = 250_000_000;
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          PROC_TIME_US   = 150;
    localparam int          PROC_CYCLES_DEF = PROC_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int          TICK_HZ        = 9600;
    localparam int          TICK_DIV_DEF   = CLK_HZ / TICK_HZ;

    // level detector thresholds on the level code, on above off
    localparam logic [15:0] LVL_ON_THR     = 16'h0100;
    localparam logic [15:0] LVL_OFF_THR    = 16'h00C0;

    // transmit table after reset: pairs a-c silent, pair d 2130 + 2750 Hz
    localparam logic [15:0][15:0] TX_DEF = {
        16'h089A, 16'h24AD, 16'h089A, 16'h1C68,
        16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // receive table after reset: unity filters, 2750 Hz and 2130 Hz checks
    localparam logic [25:0][15:0] RX_DEF = {
        16'h0039, 16'h0036, 16'h0010,
        16'h0000, 16'h0000, 16'h2000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h2000, 16'h0000, 16'h0000,
        16'h004A, 16'h0046, 16'h0010,
        16'h0000, 16'h0000, 16'h2000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h2000, 16'h0000, 16'h0000};

    // table selected by the last header
    typedef enum logic [2:0] {
        TPL_SEL_NONE = 3'b001,
        TPL_SEL_TX   = 3'b010,
        TPL_SEL_RX   = 3'b100
    } tpl_sel_t;

    // one transmit tone
    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] level;
    } tpl_tone_t;

    // one frequency check
    typedef struct packed {
        logic [15:0] ncycles;
        logic [15:0] mintime;
        logic [15:0] maxtime;
    } tpl_fchk_t;

endpackage

// >>> tb/testbench.sv
// self-checking bench for the tone pair program loader
// assumes tpl_pkg, tpl_loader and the host model tpl_host
`timescale 1ns/1ps
module testbench;
    import tpl_pkg::*;
    localparam int PROC = 8;
    logic             sys_clk_in, reset_n_in, gen_reset_in, powersave_in, ptd_mode_in;
    logic             wr_en, prog_ready_out, on1, on2, det1, det2, detp;
    logic [7:0]       addr;
    logic [15:0]      wdata, coef_out;
    logic [1:0]       pair_sel, cycle_in;
    logic [4:0]       coef_sel;
    logic [1:0][15:0] level_in;
    tpl_tone_t        tone1, tone2;
    logic [15:0]      txw [16];
    logic [15:0]      rxw [26];
    int               per [2];
    int               cnt [2];
    int               low_run, last_low, error_cnt, total_checks;

    tpl_loader #(.PROC_CYCLES(PROC), .TICK_DIV(4)) u_tpl_loader (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en),
        .addr_in(addr), .wdata_in(wdata), .prog_ready_out(prog_ready_out),
        .gen_reset_in(gen_reset_in), .powersave_in(powersave_in),
        .ptd_mode_in(ptd_mode_in), .tx_pair_sel_in(pair_sel), .tx_tone1_out(tone1),
        .tx_tone2_out(tone2), .tx_tone1_on_out(on1), .tx_tone2_on_out(on2),
        .coef_sel_in(coef_sel), .coef_out(coef_out), .cycle_in(cycle_in),
        .level_in(level_in), .tone1_det_out(det1), .tone2_det_out(det2),
        .pair_det_out(detp));
    tpl_host u_tpl_host (.sys_clk_in(sys_clk_in), .prog_ready_in(prog_ready_out),
        .wr_en_out(wr_en), .addr_out(addr), .wdata_out(wdata));

    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // busy length monitor and filtered cycle pulses
    always @(posedge sys_clk_in) begin
        low_run <= (prog_ready_out === 1'b0) ? low_run + 1 : 0;
        if (prog_ready_out === 1'b1 && low_run != 0)
            last_low <= low_run;
        for (int i = 0; i < 2; i++) begin
            cnt[i] <= (cnt[i] + 1 >= per[i]) ? 0 : cnt[i] + 1;
            cycle_in[i] <= (per[i] != 0 && cnt[i] == 0);
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic conclude();
        error_cnt += u_tpl_host.fails;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic pair_is(input logic [1:0] p, input logic [15:0] f1, l1, f2, l2);
        @(posedge sys_clk_in);
        pair_sel <= p;
        settle(3);
        check("tone1 freq", f1, tone1.freq);
        check("tone1 level", l1, tone1.level);
        check("tone2 freq", f2, tone2.freq);
        check("tone2 level", l2, tone2.level);
        check("tone1 on", {15'h0, (f1 | l1) != 16'h0}, {15'h0, on1});
        check("tone2 on", {15'h0, (f2 | l2) != 16'h0}, {15'h0, on2});
    endtask

    task automatic coef_is(input logic [4:0] i, input logic [15:0] exp);
        @(posedge sys_clk_in);
        coef_sel <= i;
        settle(3);
        check("coef", exp, coef_out);
    endtask

    task automatic reenter();
        @(posedge sys_clk_in);
        ptd_mode_in <= 1'b0;
        @(posedge sys_clk_in);
        ptd_mode_in <= 1'b1;
        settle(3);
    endtask

    task automatic ctl_pulse(input logic ps);
        @(posedge sys_clk_in);
        powersave_in <= ps;
        gen_reset_in <= ~ps;
        repeat (2) @(posedge sys_clk_in);
        powersave_in <= 1'b0;
        gen_reset_in <= 1'b0;
    endtask

    // header, one refused word, then n data words
    task automatic load(input logic [15:0] hdr, bad, input int n, input logic rx);
        u_tpl_host.write_word(hdr);
        u_tpl_host.write_word(bad);
        for (int k = 0; k < n; k++)
            u_tpl_host.write_word(rx ? rxw[k] : txw[k]);
        if (u_tpl_host.fails != 0)
            conclude();
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (prog_ready_out !== 1'b1) begin
            settle(1);
            n++;
            if (n > 100) begin
                error_cnt++;
                conclude();
            end
        end
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        reset_n_in = 1'b0;
        gen_reset_in = 1'b0;
        powersave_in = 1'b0;
        ptd_mode_in = 1'b0;
        pair_sel = 2'h0;
        coef_sel = 5'h00;
        level_in = '0;
        per = '{0, 0};
        error_cnt = 0;
        total_checks = 0;
        for (int k = 0; k < 16; k++)
            txw[k] = (k inside {[6:11]}) ? 16'h0 : 16'(16'h0321 * (k + 1));
        txw[0] = 16'h0D56;
        txw[1] = 16'h3781;
        for (int k = 0; k < 26; k++)
            rxw[k] = (k % 13 == 10) ? 16'h4 : (k % 13 == 11) ? 16'hA :
                     (k % 13 == 12) ? 16'h1E : 16'(16'h0101 * k);
        repeat (16) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        for (int p = 0; p < 3; p++)
            pair_is(2'(p), 16'h0, 16'h0, 16'h0, 16'h0);
        pair_is(2'h3, 16'h1C68, 16'h089A, 16'h24AD, 16'h089A);
        coef_is(5'h02, 16'h2000);
        coef_is(5'h0C, 16'h004A);
        coef_is(5'h19, 16'h0039);
        $display("test reset defaults done");
        u_tpl_host.target = 8'hE9;
        u_tpl_host.write_word(HDR_TX);
        settle(1);
        check("ready after other address", 16'h1, {15'h0, prog_ready_out});
        u_tpl_host.target = PROG_PORT_ADDR;
        u_tpl_host.gap = 3;
        load(HDR_TX, 16'h4000, 16, 1'b0);
        u_tpl_host.write_word(16'h1234);
        wait_ready();
        settle(2);
        check("busy time", 16'(PROC), last_low[15:0]);
        for (int p = 0; p < 4; p++)
            pair_is(2'(p), txw[4*p], txw[4*p+1], txw[4*p+2], txw[4*p+3]);
        $display("test transmit load done");
        @(posedge sys_clk_in);
        ptd_mode_in <= 1'b1;
        u_tpl_host.gap = 0;
        load(HDR_RX, 16'hFFFF, 26, 1'b1);
        u_tpl_host.write_word(16'h0777);
        wait_ready();
        coef_is(5'h0C, 16'h004A);
        reenter();
        for (int k = 0; k < 26; k++)
            coef_is(5'(k), rxw[k]);
        $display("test receive load done");
        @(posedge sys_clk_in);
        per <= '{20, 60};
        level_in <= {16'h0100, 16'h0100};
        settle(400);
        check("first tone", 16'h1, {15'h0, det1});
        check("second tone", 16'h0, {15'h0, det2});
        check("both tones", 16'h0, {15'h0, detp});
        @(posedge sys_clk_in);
        per <= '{20, 20};
        settle(400);
        check("second tone", 16'h1, {15'h0, det2});
        check("both tones", 16'h1, {15'h0, detp});
        @(posedge sys_clk_in);
        level_in[0] <= 16'h00D0;
        settle(100);
        check("first tone held", 16'h1, {15'h0, det1});
        @(posedge sys_clk_in);
        level_in[0] <= 16'h00B0;
        settle(100);
        check("first tone off", 16'h0, {15'h0, det1});
        @(posedge sys_clk_in);
        per <= '{0, 0};
        settle(200);
        check("second tone gone", 16'h0, {15'h0, det2});
        $display("test detection done");
        ctl_pulse(1'b1);
        pair_is(2'h3, 16'h0, 16'h0, 16'h0, 16'h0);
        reenter();
        coef_is(5'h0C, 16'h0000);
        ctl_pulse(1'b0);
        pair_is(2'h3, 16'h1C68, 16'h089A, 16'h24AD, 16'h089A);
        reenter();
        coef_is(5'h0C, 16'h004A);
        coef_is(5'h02, 16'h2000);
        $display("test powersave and reset done");
        conclude();
    end
endmodule

// >>> tb/tpl_host.sv
// host model: writes words to the programming port, paced by the ready flag
// assumes it shares the loader clock and changes its outputs just after an edge
`timescale 1ns/1ps
module tpl_host (
    // clock
    input  wire logic        sys_clk_in,
    // ready flag from the loader
    input  wire logic        prog_ready_in,
    // control bus write port
    output logic             wr_en_out,
    output logic [7:0]       addr_out,
    output logic [15:0]      wdata_out
);
    import tpl_pkg::*;

    logic [7:0] target;
    int         gap;
    int         fails;

    initial begin
        gap = 0;
        fails = 0;
        target = PROG_PORT_ADDR;
        wr_en_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 16'h0000;
    end

    // idle gap, wait for ready, one-cycle strobe, released bus
    task automatic write_word(input logic [15:0] w);
        int n;
        n = 0;
        repeat (gap + 1) @(posedge sys_clk_in);
        while (prog_ready_in !== 1'b1 && n < 1000) begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 1000)
            fails++;
        wr_en_out <= 1'b1;
        addr_out <= target;
        wdata_out <= w;
        @(posedge sys_clk_in);
        wr_en_out <= 1'b0;
        addr_out <= ~PROG_PORT_ADDR;
        wdata_out <= ~w;
        repeat (2) @(posedge sys_clk_in);
    endtask
endmodule
